// ===== core/urhd_consts.svh
// Offsets, field positions and reset values of the root hub descriptor block.
`ifndef URHD_CONSTS_SVH
`define URHD_CONSTS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define URHD_OFF_DESC_A   8'h00
`define URHD_OFF_DESC_B   8'h04
`define URHD_OFF_PWR_CTL  8'h08

// Descriptor A field positions.
`define URHD_NO_OVERCURRENT_PROTECT_BIT     12
`define URHD_OVERCURRENT_REPORT_GRANULARITY_BIT     11
`define URHD_DT_BIT       10
`define URHD_NPS_BIT      9
`define URHD_PSM_BIT      8
`define URHD_NDP_VALUE    8'h01

// Descriptor B field positions for the single port.
`define URHD_PORT_POWER_MASK_P1_BIT  17
`define URHD_DR_P1_BIT    1

// Power control register: write strobes and read-back status bits.
`define URHD_CMD_SET_GLB  0
`define URHD_CMD_CLR_GLB  1
`define URHD_CMD_SET_PRT  2
`define URHD_CMD_CLR_PRT  3
`define URHD_ST_POWER     0
`define URHD_ST_OC_HUB    1
`define URHD_ST_OC_PORT   2

// Reset values.
`define URHD_RST_NO_OVERCURRENT_PROTECT     1'b0
`define URHD_RST_NPS      1'b0
`define URHD_RST_PSM      1'b0
`define URHD_RST_OVERCURRENT_REPORT_GRANULARITY     `URHD_RST_PSM
`define URHD_RST_MASK_P1  1'b0
`define URHD_RST_DR_P1    1'b0

// AXI response codes.
`define URHD_RESP_OKAY    2'b00
`define URHD_RESP_SLVERR  2'b10

`endif

// ===== core/urhd_pkg.sv
// Types shared by the root hub descriptor block.
package urhd_pkg;

  // Effective port power regime derived from the descriptor bits.
  typedef enum logic [1:0] {
    PM_ALWAYS,
    PM_GLOBAL,
    PM_PERPORT
  } urhd_pmode_t;

endpackage

// ===== core/urhd_sync.sv
// Three-stage input synchroniser with agreement filter for one pin.
`timescale 1ns/100ps
`default_nettype none

module urhd_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Asynchronous input and its synchronised level
  input  wire logic pin_in,
  output var  logic level_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Stage one feeds only stage two, so metastability never reaches logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A new level counts only once stages two and three agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_out <= 1'b0;
    end else if (stage2 == stage3) begin
      level_out <= stage3;
    end
  end

endmodule

`default_nettype wire

// ===== core/urhd_regs.sv
// Root hub descriptor registers with port power control, AXI4-Lite slave.
`timescale 1ns/100ps
`default_nettype none
`include "urhd_consts.svh"

// Functional notes
// - Over-current mode 0 reports collectively, 1 reports per port.
// - Over-current mode is ignored while no-protection bit is set.
// - Over-current mode resets to the same value as power switching mode.
// - Compound-device bit always reads zero; software writes zero.
// - No-power-switching 0 means switched ports, 1 means always powered.
// - With switching enabled, switching mode picks global or per-port.
// - Switching mode 0 powers all ports together, 1 individually.
// - Switching mode counts only while no-power-switching is cleared.
// - Per-port mode: masked port obeys port commands, unmasked obeys global.
// - Downstream port count is read-only and reads one.
// - Power mask in upper half; bit 0 reserved; set bit excludes port.
// - Power mask has no effect in global switching mode.
// - Removable bits in lower half; bit 0 reserved; 1 means fixed.
// - No-protection bit at position 12; 1 means no protection.

module urhd_regs (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address channel
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  // AXI4-Lite write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // AXI4-Lite write response channel
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address channel
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  // AXI4-Lite read data channel
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // Port side
  input  wire logic        overcurrent_pin,
  output var  logic        port_power,
  output var  logic        oc_collective,
  output var  logic        oc_port,
  output var  logic        port_nonremovable
);

  //--------------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------------
  logic                 no_overcurrent_protect;
  logic                 overcurrent_report_granularity;
  logic                 no_power_switching;
  logic                 individual_power_select;
  logic                 port_power_mask_p1;
  logic                 device_nonremovable_p1;
  logic                 aw_full, w_full, do_write, rd_hit, wr_hit;
  logic                 oc_level, rd_was_a, rd_was_b;
  logic [7:0]           aw_addr_q;
  logic [3:0]           w_strb_q, cmd_pulse;
  logic [31:0]          w_data_q, byte_mask, desc_a_word, desc_b_word;
  logic [31:0]          status_word, next_desc_a, next_desc_b;
  logic [31:0]          next_cmd, rd_word;
  urhd_pkg::urhd_pmode_t pmode;

  //--------------------------------------------------------------------------
  // Over-current pin synchroniser
  //--------------------------------------------------------------------------
  // The pin is asynchronous to aclk and must be filtered before use.
  urhd_sync u_oc_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (overcurrent_pin),
    .level_out (oc_level)
  );

  //--------------------------------------------------------------------------
  // Register images
  //--------------------------------------------------------------------------
  // Descriptor A: fixed fields are constants, so writes cannot reach them.
  always_comb begin
    desc_a_word                  = 32'h0000_0000;
    desc_a_word[7:0]             = `URHD_NDP_VALUE;
    desc_a_word[`URHD_PSM_BIT]   = individual_power_select;
    desc_a_word[`URHD_NPS_BIT]   = no_power_switching;
    desc_a_word[`URHD_DT_BIT]    = 1'b0;
    desc_a_word[`URHD_OVERCURRENT_REPORT_GRANULARITY_BIT]  = overcurrent_report_granularity;
    desc_a_word[`URHD_NO_OVERCURRENT_PROTECT_BIT]  = no_overcurrent_protect;
  end

  // Descriptor B: only port 1 exists, reserved and absent bits read zero.
  always_comb begin
    desc_b_word                  = 32'h0000_0000;
    desc_b_word[`URHD_PORT_POWER_MASK_P1_BIT] = port_power_mask_p1;
    desc_b_word[`URHD_DR_P1_BIT]   = device_nonremovable_p1;
  end

  // Power control read-back shows the live port state.
  always_comb begin
    status_word                    = 32'h0000_0000;
    status_word[`URHD_ST_POWER]    = port_power;
    status_word[`URHD_ST_OC_HUB]   = oc_collective;
    status_word[`URHD_ST_OC_PORT]  = oc_port;
  end

  //--------------------------------------------------------------------------
  // Write path
  //--------------------------------------------------------------------------
  // Byte enables widen to a bit mask so partial writes keep other lanes.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{w_strb_q[i]}};
    end
  end

  assign next_desc_a = (desc_a_word & ~byte_mask) | (w_data_q & byte_mask);
  assign next_desc_b = (desc_b_word & ~byte_mask) | (w_data_q & byte_mask);
  assign next_cmd    = w_data_q & byte_mask;
  assign do_write    = aw_full && w_full && !bvalid;
  assign wr_hit      = (aw_addr_q == `URHD_OFF_DESC_A) ||
                       (aw_addr_q == `URHD_OFF_DESC_B) ||
                       (aw_addr_q == `URHD_OFF_PWR_CTL);

  // Address and data are caught independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `URHD_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full   <= 1'b1;
        aw_addr_q <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready   <= 1'b0;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? `URHD_RESP_OKAY : `URHD_RESP_SLVERR;
      end
      // Ready returns only after the response, so one write is in flight.
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Descriptor A storage; compound-device and port count are not stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      no_overcurrent_protect         <= `URHD_RST_NO_OVERCURRENT_PROTECT;
      no_power_switching             <= `URHD_RST_NPS;
      individual_power_select        <= `URHD_RST_PSM;
      overcurrent_report_granularity <= `URHD_RST_OVERCURRENT_REPORT_GRANULARITY;
    end else if (do_write && aw_addr_q == `URHD_OFF_DESC_A) begin
      no_overcurrent_protect         <= next_desc_a[`URHD_NO_OVERCURRENT_PROTECT_BIT];
      no_power_switching             <= next_desc_a[`URHD_NPS_BIT];
      individual_power_select        <= next_desc_a[`URHD_PSM_BIT];
      overcurrent_report_granularity <= next_desc_a[`URHD_OVERCURRENT_REPORT_GRANULARITY_BIT];
    end
  end

  // Descriptor B storage; absent ports have no flops, trading write-back
  // fidelity for area since software must leave those bits zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_power_mask_p1     <= `URHD_RST_MASK_P1;
      device_nonremovable_p1 <= `URHD_RST_DR_P1;
    end else if (do_write && aw_addr_q == `URHD_OFF_DESC_B) begin
      port_power_mask_p1     <= next_desc_b[`URHD_PORT_POWER_MASK_P1_BIT];
      device_nonremovable_p1 <= next_desc_b[`URHD_DR_P1_BIT];
    end
  end

  // Power commands are one-cycle strobes taken from the control register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_pulse <= 4'h0;
    end else if (do_write && aw_addr_q == `URHD_OFF_PWR_CTL) begin
      cmd_pulse <= next_cmd[3:0];
    end else begin
      cmd_pulse <= 4'h0;
    end
  end

  //--------------------------------------------------------------------------
  // Port power control
  //--------------------------------------------------------------------------
  // Switching mode is consulted only when switching exists at all.
  always_comb begin
    if (no_power_switching) begin
      pmode = urhd_pkg::PM_ALWAYS;
    end else if (individual_power_select) begin
      pmode = urhd_pkg::PM_PERPORT;
    end else begin
      pmode = urhd_pkg::PM_GLOBAL;
    end
  end

  // Set wins over clear when both arrive in one write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_power <= 1'b0;
    end else begin
      case (pmode)
        urhd_pkg::PM_ALWAYS: port_power <= 1'b1;
        urhd_pkg::PM_GLOBAL: begin
          // The mask is ignored here.
          if (cmd_pulse[`URHD_CMD_SET_GLB]) begin
            port_power <= 1'b1;
          end else if (cmd_pulse[`URHD_CMD_CLR_GLB]) begin
            port_power <= 1'b0;
          end
        end
        urhd_pkg::PM_PERPORT: begin
          if (port_power_mask_p1) begin
            if (cmd_pulse[`URHD_CMD_SET_PRT]) begin
              port_power <= 1'b1;
            end else if (cmd_pulse[`URHD_CMD_CLR_PRT]) begin
              port_power <= 1'b0;
            end
          end else begin
            if (cmd_pulse[`URHD_CMD_SET_GLB]) begin
              port_power <= 1'b1;
            end else if (cmd_pulse[`URHD_CMD_CLR_GLB]) begin
              port_power <= 1'b0;
            end
          end
        end
        default: port_power <= 1'b0;
      endcase
    end
  end

  //--------------------------------------------------------------------------
  // Over-current reporting and removable flag
  //--------------------------------------------------------------------------
  // Reporting is silenced entirely when protection is not supported.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_collective <= 1'b0;
      oc_port       <= 1'b0;
    end else begin
      oc_collective <= !no_overcurrent_protect &&
                       !overcurrent_report_granularity && oc_level;
      oc_port       <= !no_overcurrent_protect &&
                       overcurrent_report_granularity && oc_level;
    end
  end

  // The removable flag goes out registered for the hub status logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_nonremovable <= 1'b0;
    end else begin
      port_nonremovable <= device_nonremovable_p1;
    end
  end

  //--------------------------------------------------------------------------
  // Read path
  //--------------------------------------------------------------------------
  // Unmapped offsets answer with an error and zero data.
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (araddr)
      `URHD_OFF_DESC_A:  rd_word = desc_a_word;
      `URHD_OFF_DESC_B:  rd_word = desc_b_word;
      `URHD_OFF_PWR_CTL: rd_word = status_word;
      default:           rd_hit  = 1'b0;
    endcase
  end

  // Data is latched at the address handshake; ready waits for rready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h0000_0000;
      rresp    <= `URHD_RESP_OKAY;
      rd_was_a <= 1'b0;
      rd_was_b <= 1'b0;
    end else if (arvalid && arready) begin
      arready  <= 1'b0;
      rvalid   <= 1'b1;
      rdata    <= rd_word;
      rresp    <= rd_hit ? `URHD_RESP_OKAY : `URHD_RESP_SLVERR;
      rd_was_a <= (araddr == `URHD_OFF_DESC_A);
      rd_was_b <= (araddr == `URHD_OFF_DESC_B);
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  //--------------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  dt_reads_zero_a: assert property (
    rvalid && rd_was_a |-> !rdata[`URHD_DT_BIT])
    else $error("compound device bit read as one");
  ndp_reads_one_a: assert property (
    rvalid && rd_was_a |-> rdata[7:0] == `URHD_NDP_VALUE)
    else $error("port count did not read one");
  reserved_b_zero_a: assert property (
    rvalid && rd_was_b |-> rdata[31:18] == 14'h0000 &&
      rdata[16] == 1'b0 && rdata[15:2] == 14'h0000 && rdata[0] == 1'b0)
    else $error("reserved descriptor b bit read as one");
  oc_silenced_a: assert property (
    no_overcurrent_protect |=> !oc_collective && !oc_port)
    else $error("over-current reported without protection");
  oc_mode_route_a: assert property (
    !no_overcurrent_protect && oc_level |=>
      (oc_port == $past(overcurrent_report_granularity)) &&
      (oc_collective != oc_port))
    else $error("over-current routed to wrong report");
  always_powered_a: assert property (
    no_power_switching [*2] |-> port_power)
    else $error("port unpowered without power switching");
  global_ignores_mask_a: assert property (
    pmode == urhd_pkg::PM_GLOBAL && cmd_pulse[`URHD_CMD_SET_GLB] |=>
      port_power)
    else $error("global set ignored in global mode");
  masked_port_cmd_a: assert property (
    pmode == urhd_pkg::PM_PERPORT && port_power_mask_p1 &&
      cmd_pulse[`URHD_CMD_SET_PRT] |=> port_power)
    else $error("masked port ignored port set");
  masked_global_a: assert property (
    pmode == urhd_pkg::PM_PERPORT && port_power_mask_p1 &&
      cmd_pulse[3:2] == 2'b00 |=> $stable(port_power))
    else $error("masked port followed global command");
  write_response_a: assert property (
    do_write |=> bvalid ##0 !aw_full ##0 !w_full)
    else $error("write not answered one cycle after capture");

endmodule

`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking testbench for the root hub descriptor register block.
`timescale 1ns/100ps
`default_nettype none
`include "urhd_consts.svh"

module tb_top;
  // ------------------------------------------------------------------
  // Signals and constants
  // ------------------------------------------------------------------
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        arvalid, arready, rvalid, rready;
  logic        overcurrent_pin, port_power, oc_collective, oc_port;
  logic        port_nonremovable;
  int          error_cnt;
  int          total_checks;

  localparam logic [31:0] INDIVIDUAL_POWER_SELECT  = 32'h1 << `URHD_PSM_BIT;
  localparam logic [31:0] NO_POWER_SWITCHING  = 32'h1 << `URHD_NPS_BIT;
  localparam logic [31:0] OVERCURRENT_REPORT_GRANULARITY = 32'h1 << `URHD_OVERCURRENT_REPORT_GRANULARITY_BIT;
  localparam logic [31:0] NO_OVERCURRENT_PROTECT = 32'h1 << `URHD_NO_OVERCURRENT_PROTECT_BIT;
  localparam logic [31:0] MSK  = 32'h1 << `URHD_PORT_POWER_MASK_P1_BIT;
  localparam logic [31:0] DR   = 32'h1 << `URHD_DR_P1_BIT;
  localparam logic [31:0] DOWNSTREAM_PORT_COUNT  = {24'h0, `URHD_NDP_VALUE};

  // ------------------------------------------------------------------
  // Device under test
  // ------------------------------------------------------------------
  urhd_regs i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .overcurrent_pin(overcurrent_pin), .port_power(port_power),
    .oc_collective(oc_collective), .oc_port(oc_port),
    .port_nonremovable(port_nonremovable)
  );

  // Free-running 125 MHz clock.
  initial aclk = 1'b0;
  always #4 aclk = ~aclk;

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, msg, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One AXI4-Lite write; each channel is released at its own handshake.
  // The wait has no limit of its own: only the watchdog ends a lost answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] resp);
    logic done;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    resp = 2'bxx;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // One AXI4-Lite read; the answer is taken at the rvalid edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    logic done;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    d = 'x;
    resp = 2'bxx;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Full-word write that expects an OKAY response.
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
    chk({30'h0, r}, {30'h0, `URHD_RESP_OKAY}, "write response");
  endtask

  // Read that expects OKAY and a given word.
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e,
                        input string msg);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk({30'h0, r}, {30'h0, `URHD_RESP_OKAY}, "read response");
    chk(d, e, msg);
  endtask

  // The pin goes through a synchroniser, so the outputs are polled.
  task automatic wait_oc(input logic [1:0] e);
    int n;
    for (n = 0; n < 20 && {oc_collective, oc_port} !== e; n++) begin
      @(posedge aclk);
    end
    chk({30'h0, oc_collective, oc_port}, {30'h0, e}, "over-current");
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Reset values of both descriptors and of the port power output.
  task automatic t_reset();
    rd_exp(`URHD_OFF_DESC_A, DOWNSTREAM_PORT_COUNT, "desc A reset");
    rd_exp(`URHD_OFF_DESC_B, 32'h0, "desc B reset");
    chk({31'h0, port_power}, 32'h0, "power after reset");
  endtask

  // Every bit of descriptor A but the compound-device bit written high; only writable fields stick.
  task automatic t_desc_a();
    wr_ok(`URHD_OFF_DESC_A, ~(32'h1 << `URHD_DT_BIT));
    rd_exp(`URHD_OFF_DESC_A, NO_OVERCURRENT_PROTECT | OVERCURRENT_REPORT_GRANULARITY | NO_POWER_SWITCHING | INDIVIDUAL_POWER_SELECT | DOWNSTREAM_PORT_COUNT,
           "desc A ones");
    wr_ok(`URHD_OFF_DESC_A, 32'h0);
    rd_exp(`URHD_OFF_DESC_A, DOWNSTREAM_PORT_COUNT, "desc A zero");
  endtask

  // Descriptor B keeps only port 1 bits; byte strobes are honoured.
  task automatic t_desc_b();
    logic [1:0] r;
    wr_ok(`URHD_OFF_DESC_B, MSK | DR | 32'h0001_0001);
    rd_exp(`URHD_OFF_DESC_B, MSK | DR, "desc B ones");
    repeat (3) @(posedge aclk);
    chk({31'h0, port_nonremovable}, 32'h1, "fixed device");
    wr(`URHD_OFF_DESC_B, 32'h0, 4'h1, r);
    chk({30'h0, r}, {30'h0, `URHD_RESP_OKAY}, "strobed write");
    rd_exp(`URHD_OFF_DESC_B, MSK, "desc B low byte");
    wr_ok(`URHD_OFF_DESC_B, 32'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, port_nonremovable}, 32'h0, "removable device");
  endtask

  // Unmapped place answers SLVERR and leaves descriptor A alone.
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h40, 32'hffffffff, 4'hf, r);
    chk({30'h0, r}, {30'h0, `URHD_RESP_SLVERR}, "unmapped write");
    rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, `URHD_RESP_SLVERR}, "unmapped read");
    chk(d, 32'h0, "unmapped data");
    rd_exp(`URHD_OFF_DESC_A, DOWNSTREAM_PORT_COUNT, "desc A untouched");
  endtask

  // Power commands under every switching regime, driven from a table.
  task automatic t_power();
    logic [31:0] ta [16] = '{0, 0, 0, 0, 0, INDIVIDUAL_POWER_SELECT, INDIVIDUAL_POWER_SELECT, INDIVIDUAL_POWER_SELECT, INDIVIDUAL_POWER_SELECT, INDIVIDUAL_POWER_SELECT, INDIVIDUAL_POWER_SELECT,
                             INDIVIDUAL_POWER_SELECT, INDIVIDUAL_POWER_SELECT, NO_POWER_SWITCHING | INDIVIDUAL_POWER_SELECT, NO_POWER_SWITCHING, 0};
    logic [31:0] tb [16] = '{0, MSK, MSK, MSK, MSK, MSK, MSK, MSK, MSK,
                             0, 0, 0, 0, MSK, 0, 0};
    int          tc [16] = '{1, 2, 0, 3, 1, 0, 2, 1, 3, 2, 0, 3, 1, 1, 1, 1};
    logic        te [16] = '{0, 0, 1, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 1, 0};
    int          i;
    for (i = 0; i < 16; i++) begin
      wr_ok(`URHD_OFF_DESC_A, ta[i]);
      wr_ok(`URHD_OFF_DESC_B, tb[i]);
      wr_ok(`URHD_OFF_PWR_CTL, 32'h1 << tc[i]);
      repeat (3) @(posedge aclk);
      chk({31'h0, port_power}, {31'h0, te[i]},
          "port power");
      rd_exp(`URHD_OFF_PWR_CTL, {31'h0, te[i]}, "power status");
    end
  endtask

  // Over-current reporting in each mode with protection, and in per-port mode without it.
  task automatic t_overcurrent();
    wr_ok(`URHD_OFF_DESC_A, 32'h0);
    @(posedge aclk);
    overcurrent_pin <= 1'b1;
    wait_oc(2'b10);
    rd_exp(`URHD_OFF_PWR_CTL, 32'h1 << `URHD_ST_OC_HUB, "hub status");
    wr_ok(`URHD_OFF_DESC_A, OVERCURRENT_REPORT_GRANULARITY);
    wait_oc(2'b01);
    rd_exp(`URHD_OFF_PWR_CTL, 32'h1 << `URHD_ST_OC_PORT, "oc port");
    wr_ok(`URHD_OFF_DESC_A, OVERCURRENT_REPORT_GRANULARITY | NO_OVERCURRENT_PROTECT);
    wait_oc(2'b00);
    wr_ok(`URHD_OFF_DESC_A, 32'h0);
    wait_oc(2'b10);
    @(posedge aclk);
    overcurrent_pin <= 1'b0;
    wait_oc(2'b00);
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  // Inputs get values at time zero; reset is held for 12 cycles.
  initial begin
    error_cnt = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    overcurrent_pin = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_desc_a();
    t_desc_b();
    t_unmapped();
    t_power();
    t_overcurrent();
    end_sim();
  end

  // The whole run needs a few hundred cycles; this cuts a hang short.
  initial begin
    #200000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
